// [fwg_pkg.sv]
package fwg_pkg;
	localparam logic [7:0] FWG_ADDR_DISCH = 8'h05;
	localparam logic [7:0] FWG_ADDR_CHARGE = 8'h06;
	localparam logic [7:0] FWG_ADDR_FEATURE = 8'h07;
	localparam logic [7:0] FWG_ADDR_GUARD = 8'h08;
	localparam logic [7:0] FWG_RESET_VAL = 8'h00;
	localparam logic [7:0] FWG_GUARD_MASK = 8'hf8;
	localparam int FWG_BIT_ATS_OFF = 7;
	localparam int FWG_BIT_REG_DIS = 6;
	localparam int FWG_BIT_SENS_ON = 5;
	localparam int FWG_BIT_XTSD_DIS = 4;
	localparam int FWG_BIT_ITSD_DIS = 3;
	localparam int FWG_BIT_FRST = 2;
	localparam int FWG_BIT_WAKE_DIS = 1;
	localparam int FWG_BIT_WAKE_POL = 0;
	localparam int FWG_BIT_FEAT_UNL = 7;
	localparam int FWG_BIT_CHG_UNL = 6;
	localparam int FWG_BIT_DIS_UNL = 5;
	localparam int FWG_CLK_MHZ = 100;
	localparam int FWG_SCAN_ON_MS = 5;
	localparam int FWG_SCAN_PERIOD_MS = 640;
	localparam int FWG_SCAN_ON_CYC = FWG_SCAN_ON_MS * FWG_CLK_MHZ * 1000;
	localparam int FWG_SCAN_PERIOD_CYC = FWG_SCAN_PERIOD_MS * FWG_CLK_MHZ * 1000;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fwg_req_t;

	typedef struct packed {
		logic auto_temp_scan_off;
		logic regulator_disable;
		logic sensor_supply_keep_on;
		logic ext_thermal_shutdown_disable;
		logic int_thermal_shutdown_disable;
		logic forced_reset_bit;
		logic wake_pin_disable;
		logic wake_polarity;
	} fwg_feat_t;
endpackage

// [fwg_scan_timer.sv]
`timescale 1ns/1ns
module fwg_scan_timer
	import fwg_pkg::*;
#(
	parameter int PERIOD_CYC = FWG_SCAN_PERIOD_CYC,
	parameter int ON_CYC = FWG_SCAN_ON_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic clr,
	input wire logic enable,
	output logic scan_on_ff
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff + 32'h1;
		if (cnt_ff == 32'(PERIOD_CYC - 1)) begin
			nxt_cnt = 32'h0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 32'h0;
			scan_on_ff <= 1'b0;
		end else if (ce) begin
			if (clr || !enable) begin
				cnt_ff <= 32'h0;
				scan_on_ff <= 1'b0;
			end else begin
				cnt_ff <= nxt_cnt;
				scan_on_ff <= (nxt_cnt < 32'(ON_CYC));
			end
		end
	end
endmodule

// [fwg_regs.sv]
`timescale 1ns/1ns
// Operation
// - Scan bit 0 powers external sensing 5ms per 640ms; 1 suppresses it.
// - Regulator disable bit switches off the internal regulator.
// - Keep-on bit holds sensor supply on regardless of scan timing.
// - External thermal shutdown disable blocks automatic transistor turn-off.
// - Internal thermal shutdown disable blocks automatic transistor turn-off.
// - Forced reset bit clears the feature and guard registers to zero.
// - Wake pin disable ignores wake pin; only serial access re-enables.
// - Wake polarity 1 wakes on rising edge, 0 on falling.
// - Feature register writes only take effect while feature unlock is 1.
// - Charge register writes only take effect while charge unlock is 1.
// - Discharge register writes only take effect while discharge unlock is 1.
// - All unlock bits are 0 after power-up.
// - Guard bits 4 and 3 are retained user flags.
// - Guard bits 2 to 0 are reserved, read zero.
module fwg_regs
	import fwg_pkg::*;
#(
	parameter int PERIOD_CYC = FWG_SCAN_PERIOD_CYC,
	parameter int ON_CYC = FWG_SCAN_ON_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	input wire fwg_req_t req,
	input wire logic wake_pin,
	input wire logic ext_over_temp,
	input wire logic int_over_temp,
	input wire logic asleep,
	output logic [7:0] rdata_ff,
	output fwg_feat_t feat_ff,
	output logic [7:0] guard_ff,
	output logic charge_wr_ok_ff,
	output logic disch_wr_ok_ff,
	output logic regulator_on_ff,
	output logic sensor_supply_ff,
	output logic fet_shutdown_ff,
	output logic wake_event_ff
);
	logic scan_on_ff;
	logic wake_prev_ff;
	logic frst;
	logic feat_wr;
	logic guard_wr;
	logic wake_edge;
	logic [31:0] on_run_ff;

	assign frst = feat_ff.forced_reset_bit;
	assign feat_wr = req.wr && req.addr == FWG_ADDR_FEATURE && guard_ff[FWG_BIT_FEAT_UNL];
	assign guard_wr = req.wr && req.addr == FWG_ADDR_GUARD;
	assign wake_edge = feat_ff.wake_polarity ? (wake_pin && !wake_prev_ff)
		: (!wake_pin && wake_prev_ff);

	////////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			feat_ff <= fwg_feat_t'(FWG_RESET_VAL);
			guard_ff <= FWG_RESET_VAL;
		end else if (ce) begin
			if (frst) begin
				feat_ff <= fwg_feat_t'(FWG_RESET_VAL);
				guard_ff <= FWG_RESET_VAL;
			end else begin
				if (feat_wr) begin
					feat_ff <= fwg_feat_t'(req.wdata);
				end
				if (guard_wr) begin
					guard_ff <= req.wdata & FWG_GUARD_MASK;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			charge_wr_ok_ff <= 1'b0;
			disch_wr_ok_ff <= 1'b0;
		end else if (ce) begin
			charge_wr_ok_ff <= !frst && req.wr && req.addr == FWG_ADDR_CHARGE
				&& guard_ff[FWG_BIT_CHG_UNL];
			disch_wr_ok_ff <= !frst && req.wr && req.addr == FWG_ADDR_DISCH
				&& guard_ff[FWG_BIT_DIS_UNL];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= FWG_RESET_VAL;
		end else if (ce) begin
			if (req.rd && req.addr == FWG_ADDR_FEATURE) begin
				rdata_ff <= feat_ff;
			end else if (req.rd && req.addr == FWG_ADDR_GUARD) begin
				rdata_ff <= guard_ff;
			end else if (req.rd) begin
				rdata_ff <= FWG_RESET_VAL;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Controlled functions
	fwg_scan_timer #(.PERIOD_CYC(PERIOD_CYC), .ON_CYC(ON_CYC)) u_scan (
		.mclk(mclk),
		.arst_n(arst_n),
		.ce(ce),
		.clr(frst),
		.enable(!feat_ff.auto_temp_scan_off),
		.scan_on_ff(scan_on_ff)
	);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			regulator_on_ff <= 1'b1;
			sensor_supply_ff <= 1'b0;
			fet_shutdown_ff <= 1'b0;
		end else if (ce) begin
			regulator_on_ff <= !feat_ff.regulator_disable;
			sensor_supply_ff <= feat_ff.sensor_supply_keep_on || scan_on_ff;
			fet_shutdown_ff <= (ext_over_temp && !feat_ff.ext_thermal_shutdown_disable)
				|| (int_over_temp && !feat_ff.int_thermal_shutdown_disable);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wake_prev_ff <= 1'b0;
			wake_event_ff <= 1'b0;
		end else if (ce) begin
			wake_prev_ff <= wake_pin;
			wake_event_ff <= asleep && wake_edge && !feat_ff.wake_pin_disable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Length of the current scan window, watched by the checks
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			on_run_ff <= 32'h0;
		end else if (ce) begin
			if (scan_on_ff) begin
				on_run_ff <= on_run_ff + 32'h1;
			end else begin
				on_run_ff <= 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_feat_locked: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && req.wr && req.addr == FWG_ADDR_FEATURE && !guard_ff[FWG_BIT_FEAT_UNL] && !frst
		|=> $stable(feat_ff)) else $error("Locked feature write changed register");
	a_feat_write: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && feat_wr && !frst |=> feat_ff == fwg_feat_t'($past(req.wdata)))
		else $error("Unlocked feature write lost");
	a_charge_gate: assert property (@(posedge mclk) disable iff (!arst_n)
		charge_wr_ok_ff |-> $past(guard_ff[FWG_BIT_CHG_UNL]))
		else $error("Charge write passed while locked");
	a_charge_lock: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && req.wr && req.addr == FWG_ADDR_CHARGE && !guard_ff[FWG_BIT_CHG_UNL]
		|=> !charge_wr_ok_ff) else $error("Locked charge write accepted");
	a_disch_gate: assert property (@(posedge mclk) disable iff (!arst_n)
		disch_wr_ok_ff |-> $past(guard_ff[FWG_BIT_DIS_UNL]))
		else $error("Discharge write passed while locked");
	a_disch_lock: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && req.wr && req.addr == FWG_ADDR_DISCH && !guard_ff[FWG_BIT_DIS_UNL]
		|=> !disch_wr_ok_ff) else $error("Locked discharge write accepted");
	a_guard_write: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && guard_wr && !frst |=> guard_ff == ($past(req.wdata) & FWG_GUARD_MASK))
		else $error("Guard write lost");
	a_reserved_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		(guard_ff & ~FWG_GUARD_MASK) == FWG_RESET_VAL) else $error("Reserved guard bits set");

	sequence s_frst_set;
		ce && frst;
	endsequence
	sequence s_all_clear;
		feat_ff == fwg_feat_t'(FWG_RESET_VAL) && guard_ff == FWG_RESET_VAL;
	endsequence
	a_forced_clear: assert property (@(posedge mclk) disable iff (!arst_n)
		s_frst_set |=> s_all_clear) else $error("Forced reset left state");
	a_rd_feature: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && req.rd && req.addr == FWG_ADDR_FEATURE |=> rdata_ff == $past(feat_ff))
		else $error("Feature read back wrong");

	a_scan_off: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && feat_ff.auto_temp_scan_off |=> !scan_on_ff)
		else $error("Scan ran while switched off");
	a_scan_len: assert property (@(posedge mclk) disable iff (!arst_n)
		on_run_ff <= 32'(ON_CYC)) else $error("Scan window too long");
	a_sensor_keep: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && feat_ff.sensor_supply_keep_on && $past(ce) |=> sensor_supply_ff)
		else $error("Sensor supply not held on");
	a_sensor_off: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && !feat_ff.sensor_supply_keep_on && !scan_on_ff |=> !sensor_supply_ff)
		else $error("Sensor supply on outside scan");
	a_reg_off: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && feat_ff.regulator_disable |=> !regulator_on_ff)
		else $error("Regulator stayed on");
	a_reg_on: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && !feat_ff.regulator_disable |=> regulator_on_ff)
		else $error("Regulator switched off");

	a_fet_ext: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && ext_over_temp && !feat_ff.ext_thermal_shutdown_disable |=> fet_shutdown_ff)
		else $error("External over-temp shutdown missed");
	a_fet_int: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && int_over_temp && !feat_ff.int_thermal_shutdown_disable |=> fet_shutdown_ff)
		else $error("Internal over-temp shutdown missed");
	a_fet_masked: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && !(ext_over_temp && !feat_ff.ext_thermal_shutdown_disable)
		&& !(int_over_temp && !feat_ff.int_thermal_shutdown_disable)
		|=> !fet_shutdown_ff) else $error("Shutdown without cause");

	a_wake_masked: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && feat_ff.wake_pin_disable |=> !wake_event_ff)
		else $error("Wake while pin disabled");
	a_wake_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && feat_ff.wake_pin_disable && !feat_wr && !frst |=> feat_ff.wake_pin_disable)
		else $error("Wake disable cleared without a write");
	sequence s_rise_seen;
		ce && $past(ce) && asleep && !feat_ff.wake_pin_disable && feat_ff.wake_polarity
			&& $rose(wake_pin);
	endsequence
	sequence s_fall_seen;
		ce && $past(ce) && asleep && !feat_ff.wake_pin_disable && !feat_ff.wake_polarity
			&& $fell(wake_pin);
	endsequence
	a_wake_rise: assert property (@(posedge mclk) disable iff (!arst_n)
		s_rise_seen |=> wake_event_ff) else $error("Rising wake edge missed");
	a_wake_fall: assert property (@(posedge mclk) disable iff (!arst_n)
		s_fall_seen |=> wake_event_ff) else $error("Falling wake edge missed");
endmodule

// [fwg_host.sv]
`timescale 1ns/1ns
module fwg_host
	import fwg_pkg::*;
#(
	parameter bit LOWER_DEV = 1'b0
) (
	input wire logic mclk,
	input wire logic ext_ot,
	input wire logic int_ot,
	input wire fwg_feat_t feat,
	output logic host_trip,
	output fwg_req_t req
);
	initial req = '0;
	// Host takes over the shutdowns the device was told to skip
	assign host_trip = (ext_ot && feat.ext_thermal_shutdown_disable)
		|| (int_ot && feat.int_thermal_shutdown_disable);
	// One-cycle request off the falling edge, an idle cycle behind it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		if (LOWER_DEV && w && a == FWG_ADDR_FEATURE) begin
			d[FWG_BIT_WAKE_POL] = 1'b0;
		end
		@(negedge mclk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge mclk);
		req <= '0;
	endtask
endmodule

// [feature_and_write_guard_regs_tb.sv]
`timescale 1ns/1ns
module feature_and_write_guard_regs_tb;
	import fwg_pkg::*;
	logic mclk = 0;
	logic arst_n = 0;
	logic wake_pin = 1;
	logic ext_ot = 0;
	logic int_ot = 0;
	logic asleep = 0;
	fwg_req_t req;
	logic [7:0] rdata;
	logic [7:0] guard;
	fwg_feat_t feat;
	logic chg_ok, dis_ok, reg_on, sens, fet, wake;
	logic ce = 1;
	logic trip;
	int bad_count = 0;
	int checks_done = 0;
	int seed = 32'h9b280678;
	int c;
	logic [7:0] v;
	logic [7:0] g;
	logic [7:0] wt [5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02};
	always #5 mclk = ~mclk;
	fwg_host host (.mclk(mclk), .ext_ot(ext_ot), .int_ot(int_ot), .feat(feat), .host_trip(trip),
		.req(req));
	fwg_regs #(.PERIOD_CYC(64), .ON_CYC(5)) dut (.mclk(mclk), .arst_n(arst_n), .ce(ce),
		.req(req), .wake_pin(wake_pin), .ext_over_temp(ext_ot), .int_over_temp(int_ot),
		.asleep(asleep), .rdata_ff(rdata), .feat_ff(feat), .guard_ff(guard),
		.charge_wr_ok_ff(chg_ok), .disch_wr_ok_ff(dis_ok), .regulator_on_ff(reg_on),
		.sensor_supply_ff(sens), .fet_shutdown_ff(fet), .wake_event_ff(wake));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic count_hi(input bit w, input int n);
		c = 0;
		repeat (n) begin
			@(negedge mclk);
			c += w ? wake : sens;
		end
	endtask
	function automatic logic [7:0] exp_fet(input logic [7:0] f, input logic x, input logic i);
		return {7'h0, (x & !f[4]) | (i & !f[3])};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		bad_count++;
		summarize();
	end
	initial begin
		repeat (16) @(negedge mclk);
		arst_n = 1;
		chk("guard", guard, FWG_RESET_VAL);
		chk("feature", feat, FWG_RESET_VAL);
		chk("reg_on", {7'h0, reg_on}, 8'h01);
		host.xfer(1, FWG_ADDR_FEATURE, 8'h40);
		chk("locked feature", feat, 8'h00);
		host.xfer(1, FWG_ADDR_CHARGE, 8'h11);
		chk("locked charge", {7'h0, chg_ok}, 8'h00);
		v = $random(seed);
		g = (v | 8'he7) & FWG_GUARD_MASK;
		host.xfer(1, FWG_ADDR_GUARD, v | 8'he7);
		chk("guard", guard, g);
		host.xfer(0, FWG_ADDR_GUARD, 8'h00);
		chk("guard read", rdata, g);
		host.xfer(1, FWG_ADDR_CHARGE, v);
		chk("charge ok", {7'h0, chg_ok}, 8'h01);
		host.xfer(1, FWG_ADDR_DISCH, v);
		chk("disch ok", {7'h0, dis_ok}, 8'h01);
		host.xfer(0, 8'h3c, 8'h00);
		chk("unmapped read", rdata, 8'h00);
		// Clock enable low freezes every register
		ce = 0;
		host.xfer(1, FWG_ADDR_GUARD, 8'h00);
		chk("frozen guard", guard, g);
		ce = 1;
		$display("guard test done");
		for (int i = 0; i < 6; i++) begin
			v = (i < 2) ? (i ? 8'h18 : 8'h00) : ($random(seed) & 8'hf9);
			ext_ot = (i < 2) ? 1'b1 : 1'($random(seed));
			int_ot = (i < 2) ? 1'b1 : 1'($random(seed));
			host.xfer(1, FWG_ADDR_FEATURE, v);
			chk("feature", feat, v);
			host.xfer(0, FWG_ADDR_FEATURE, 8'h00);
			chk("feature read", rdata, v);
			repeat (2) @(negedge mclk);
			chk("reg_on", {7'h0, reg_on}, {7'h0, !v[6]});
			if (v[5]) chk("sensor", {7'h0, sens}, 8'h01);
			chk("fet", {7'h0, fet}, exp_fet(v, ext_ot, int_ot));
			chk("pack off", {7'h0, fet || trip}, {7'h0, ext_ot || int_ot});
			chk("guard kept", guard, g);
		end
		host.xfer(1, FWG_ADDR_FEATURE, 8'h00);
		// Supply trails the scan timer by one more cycle
		@(negedge mclk);
		count_hi(0, 64);
		chk("scan on", 8'(c), 8'h05);
		host.xfer(1, FWG_ADDR_FEATURE, 8'h80);
		@(negedge mclk);
		count_hi(0, 64);
		chk("scan off", 8'(c), 8'h00);
		$display("feature test done");
		asleep = 1;
		for (int i = 0; i < 5; i++) begin
			host.xfer(1, FWG_ADDR_FEATURE, wt[i]);
			wake_pin = i[0];
			count_hi(1, 4);
			chk("wake", 8'(c), {7'h0, (i == 0) || (i == 3)});
		end
		$display("wake test done");
		host.xfer(1, FWG_ADDR_FEATURE, 8'h04);
		repeat (2) @(negedge mclk);
		chk("forced feature", feat, 8'h00);
		chk("forced guard", guard, 8'h00);
		host.xfer(0, FWG_ADDR_FEATURE, 8'h00);
		chk("forced read", rdata, 8'h00);
		host.xfer(1, FWG_ADDR_FEATURE, 8'h20);
		chk("relocked", feat, 8'h00);
		$display("forced reset test done");
		summarize();
	end
endmodule
